/* logic/dsau_top.sv */
// data space decode, byte lanes, alignment trap and working register load
`include "dsau_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - separate 16-bit read and write paths
// - 16-bit byte effective addresses, 64 Kbytes
// - bit 15 set routes reads to visibility window
// - unimplemented data reads return zero
// - low byte even address, high odd
// - post-increment by one byte, two word
// - byte read fetches word, lands low
// - shared word decode, per-lane write strobes
// - odd word access raises address error trap
// - misaligned read completes, misaligned write suppressed
// - byte load keeps register high byte
// - sign widen and upper clear operations
// - low 2 Kbytes are registers, gaps zero
// - near 8 Kbytes via 13-bit field
// - full space via direct or pointer
module dsau_top
#(
   parameter logic [15:0] RAM_LAST = `DSAU_RAM_LAST,
   parameter int          RAM_WORDS = 8192
)
(
   // clock and reset
   input  wire logic                    clk_sys_in,
   input  wire logic                    rst_in,
   // read address generator
   input  wire dsau_pkg::dsau_req_t     rd_req_in,
   input  wire dsau_pkg::dsau_ext_t     rd_ext_op_in,
   input  wire logic [15:0]             rd_wreg_old_in,
   // write address generator
   input  wire dsau_pkg::dsau_req_t     wr_req_in,
   input  wire logic [15:0]             wr_data_in,
   // read answer
   output logic                         rd_valid_out,
   output logic [15:0]                  rd_data_out,
   output logic [15:0]                  rd_wreg_out,
   output logic [15:0]                  rd_ptr_next_out,
   output logic [15:0]                  wr_ptr_next_out,
   // address error trap
   output logic                         addr_err_trap_out,
   output logic                         addr_err_write_out,
   // special function registers
   output logic                         sfr_rd_en_out,
   output logic [15:0]                  sfr_rd_addr_out,
   input  wire logic [15:0]             sfr_rd_data_in,
   input  wire logic                    sfr_rd_hit_in,
   output logic [1:0]                   sfr_wr_lane_out,
   output logic [15:0]                  sfr_wr_addr_out,
   output logic [15:0]                  sfr_wr_data_out,
   // program space visibility window
   output logic                         psv_rd_en_out,
   output logic [14:0]                  psv_addr_out,
   input  wire logic [15:0]             psv_rd_data_in
);

   ////////////////////////////////////////////////////////////////////////////
   // shared address arithmetic
   function automatic logic [15:0] calc_ea(input dsau_pkg::dsau_req_t req);
      logic [15:0] ea;
      ea = req.field;
      if (req.mode == dsau_pkg::DSAU_AM_NEAR)
         ea = {3'h0, req.field[`DSAU_NEAR_BITS-1:0]};
      else if (req.mode == dsau_pkg::DSAU_AM_INDIRECT)
         ea = req.pointer;
      return ea;
   endfunction : calc_ea

   function automatic logic [15:0] calc_ptr(input dsau_pkg::dsau_req_t req);
      logic [15:0] step;
      step = req.is_byte ? `DSAU_BYTE_STEP : `DSAU_WORD_STEP;
      if (req.mode == dsau_pkg::DSAU_AM_INDIRECT && req.post_inc)
         return 16'(req.pointer + step);
      return req.pointer;
   endfunction : calc_ptr

   function automatic logic is_sfr(input logic [15:0] ea);
      return ea <= `DSAU_SFR_LAST;
   endfunction : is_sfr

   function automatic logic is_ram(input logic [15:0] ea);
      return !ea[`DSAU_PSV_BIT] && ea > `DSAU_SFR_LAST && ea <= RAM_LAST;
   endfunction : is_ram

   ////////////////////////////////////////////////////////////////////////////
   // byte lane arrays: one word decode, two write strobes
   logic [7:0]  ram_lo [RAM_WORDS];
   logic [7:0]  ram_hi [RAM_WORDS];

   logic [15:0] rd_ea;
   logic [15:0] wr_ea;
   logic        rd_misalign;
   logic        wr_misalign;
   logic [12:0] rd_index;
   logic [12:0] wr_index;
   logic [15:0] rd_word;
   logic [15:0] rd_sel;
   logic [15:0] rd_merge;
   logic [1:0]  ram_we;
   logic [15:0] wr_lane_data;

   assign rd_ea       = calc_ea(rd_req_in);
   assign wr_ea       = calc_ea(wr_req_in);
   assign rd_misalign = rd_req_in.valid && !rd_req_in.is_byte && rd_ea[0];
   assign wr_misalign = wr_req_in.valid && !wr_req_in.is_byte && wr_ea[0];
   assign rd_index    = rd_ea[13:1];
   assign wr_index    = wr_ea[13:1];

   ////////////////////////////////////////////////////////////////////////////
   // read decode; the whole word is always fetched
   always_comb
   begin
      sfr_rd_en_out   = 1'b0;
      psv_rd_en_out   = 1'b0;
      sfr_rd_addr_out = {rd_ea[15:1], 1'b0};
      psv_addr_out    = rd_ea[14:0];
      rd_word         = `DSAU_RST_DATA;
      if (rd_req_in.valid && rd_ea[`DSAU_PSV_BIT])
      begin
         psv_rd_en_out = 1'b1;
         rd_word       = psv_rd_data_in;
      end
      else if (rd_req_in.valid && is_sfr(rd_ea))
      begin
         sfr_rd_en_out = 1'b1;
         rd_word       = sfr_rd_hit_in ? sfr_rd_data_in : `DSAU_RST_DATA;
      end
      else if (rd_req_in.valid && is_ram(rd_ea))
      begin
         rd_word = {ram_hi[rd_index], ram_lo[rd_index]};
      end
      // anything else stays zero
      if (rd_req_in.is_byte)
         rd_sel = {8'h00, rd_ea[0] ? rd_word[15:8] : rd_word[7:0]};
      else
         rd_sel = rd_word;
   end

   dsau_ext_unit u_ext
   (
      .op_in       (rd_ext_op_in),
      .data_in     (rd_sel),
      .wreg_old_in (rd_wreg_old_in),
      .wreg_out    (rd_merge)
   );

   ////////////////////////////////////////////////////////////////////////////
   // write decode; an odd word write never reaches any lane
   always_comb
   begin
      ram_we          = 2'h0;
      sfr_wr_lane_out = 2'h0;
      sfr_wr_addr_out = {wr_ea[15:1], 1'b0};
      wr_lane_data    = wr_req_in.is_byte ? {2{wr_data_in[7:0]}} : wr_data_in;
      if (wr_req_in.valid && !wr_misalign)
      begin
         if (is_sfr(wr_ea))
         begin
            if (wr_req_in.is_byte)
               sfr_wr_lane_out = wr_ea[0] ? 2'h2 : 2'h1;
            else
               sfr_wr_lane_out = 2'h3;
         end
         else if (is_ram(wr_ea))
         begin
            if (wr_req_in.is_byte)
               ram_we = wr_ea[0] ? 2'h2 : 2'h1;
            else
               ram_we = 2'h3;
         end
         // window and unmapped writes are dropped
      end
      sfr_wr_data_out = wr_lane_data;
   end

   // array is not reset; a read of a word written in the same cycle sees the old value
   always_ff @(posedge clk_sys_in)
   begin
      if (ram_we[0])
         ram_lo[wr_index] <= wr_lane_data[7:0];
      if (ram_we[1])
         ram_hi[wr_index] <= wr_lane_data[15:8];
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered answer and trap
   logic        next_rd_valid;
   logic [15:0] next_rd_data;
   logic [15:0] next_rd_wreg;
   logic [15:0] next_rd_ptr;
   logic [15:0] next_wr_ptr;
   logic        next_trap;
   logic        next_trap_wr;

   always_comb
   begin
      // a misaligned read still completes, so the answer is given as well
      next_rd_valid = rd_req_in.valid;
      next_rd_data  = rd_sel;
      next_rd_wreg  = rd_merge;
      next_rd_ptr   = rd_req_in.valid ? calc_ptr(rd_req_in) : rd_ptr_next_out;
      next_wr_ptr   = wr_req_in.valid ? calc_ptr(wr_req_in) : wr_ptr_next_out;
      next_trap     = rd_misalign || wr_misalign;
      next_trap_wr  = wr_misalign;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_valid_out       <= 1'b0;
         rd_data_out        <= `DSAU_RST_DATA;
         rd_wreg_out        <= `DSAU_RST_DATA;
         rd_ptr_next_out    <= `DSAU_RST_ADDR;
         wr_ptr_next_out    <= `DSAU_RST_ADDR;
         addr_err_trap_out  <= 1'b0;
         addr_err_write_out <= 1'b0;
      end
      else
      begin
         rd_valid_out       <= next_rd_valid;
         rd_data_out        <= next_rd_data;
         rd_wreg_out        <= next_rd_wreg;
         rd_ptr_next_out    <= next_rd_ptr;
         wr_ptr_next_out    <= next_wr_ptr;
         addr_err_trap_out  <= next_trap;
         addr_err_write_out <= next_trap_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   psv_route_a : assert property (
      rd_req_in.valid && rd_ea[15] |-> psv_rd_en_out && !sfr_rd_en_out)
      else $error("window read not routed to window");

   sfr_route_a : assert property (
      rd_req_in.valid && !rd_ea[15] && rd_ea <= 16'h07ff |-> sfr_rd_en_out && !psv_rd_en_out)
      else $error("register read not routed to registers");

   unimpl_zero_a : assert property (
      rd_req_in.valid && !rd_ea[15] && rd_ea > RAM_LAST |=> rd_data_out == 16'h0000)
      else $error("unimplemented read not zero");

   ptr_step_a : assert property (
      rd_req_in.valid && rd_req_in.post_inc && rd_req_in.mode == dsau_pkg::DSAU_AM_INDIRECT
      |=> rd_ptr_next_out == 16'($past(rd_req_in.pointer)
                                 + ($past(rd_req_in.is_byte) ? 16'h0001 : 16'h0002)))
      else $error("pointer step wrong");

   byte_read_a : assert property (
      rd_req_in.valid && rd_req_in.is_byte |=> rd_data_out[15:8] == 8'h00)
      else $error("byte read not on low lane");

   byte_lane_a : assert property (
      wr_req_in.valid && wr_req_in.is_byte && is_sfr(wr_ea)
      |-> sfr_wr_lane_out == (wr_ea[0] ? 2'h2 : 2'h1))
      else $error("byte write strobe on wrong lane");

   trap_pair_a : assert property (
      rd_misalign || wr_misalign |=> addr_err_trap_out ##1 !addr_err_trap_out || $past(next_trap))
      else $error("address error trap missing");

   read_complete_a : assert property (
      rd_misalign |=> rd_valid_out && addr_err_trap_out)
      else $error("misaligned read not completed");

   write_suppress_a : assert property (
      wr_misalign |-> ram_we == 2'h0 && sfr_wr_lane_out == 2'h0)
      else $error("misaligned write not suppressed");

   byte_keep_a : assert property (
      rd_req_in.valid && rd_ext_op_in == dsau_pkg::DSAU_EXT_BYTE
      |=> rd_wreg_out[15:8] == $past(rd_wreg_old_in[15:8]))
      else $error("byte load touched high byte");

   sfr_gap_a : assert property (
      rd_req_in.valid && is_sfr(rd_ea) && !sfr_rd_hit_in |=> rd_data_out == 16'h0000)
      else $error("unused register address not zero");

   near_form_a : assert property (
      rd_req_in.valid && rd_req_in.mode == dsau_pkg::DSAU_AM_NEAR
      |-> rd_ea[15:13] == 3'h0 && rd_ea[12:0] == rd_req_in.field[12:0])
      else $error("near address outside near space");

   quiet_drop_a : assert property (
      wr_req_in.valid && !wr_misalign && !is_sfr(wr_ea) && !is_ram(wr_ea)
      |-> ram_we == 2'h0 && sfr_wr_lane_out == 2'h0 ##1 !addr_err_trap_out || $past(rd_misalign))
      else $error("unmapped write had an effect");

   ram_read_c  : cover property (rd_req_in.valid && is_ram(rd_ea) && rd_req_in.is_byte);
   odd_write_c : cover property (wr_misalign);
   psv_read_c  : cover property (rd_req_in.valid && rd_ea[15] ##1 rd_valid_out);
   sfr_byte_c  : cover property (wr_req_in.valid && wr_req_in.is_byte && sfr_wr_lane_out != 2'h0);
   drop_wr_c   : cover property (
      wr_req_in.valid && !wr_misalign && !is_sfr(wr_ea) && !is_ram(wr_ea));
endmodule : dsau_top

/* logic/dsau_defines.svh */
// address map, steps and reset values of the data space access unit
`ifndef DSAU_DEFINES_SVH
`define DSAU_DEFINES_SVH
`define DSAU_ADDR_W     16
`define DSAU_PSV_BIT    15
`define DSAU_SFR_LAST   16'h07ff
`define DSAU_RAM_LAST   16'h3fff
`define DSAU_NEAR_BITS  13
`define DSAU_BYTE_STEP  16'h0001
`define DSAU_WORD_STEP  16'h0002
`define DSAU_RST_DATA   16'h0000
`define DSAU_RST_ADDR   16'h0000
`endif

/* logic/dsau_pkg.sv */
// types shared by the data space access unit
package dsau_pkg;
   typedef enum logic [1:0]
   {
      DSAU_AM_DIRECT   = 2'h0,
      DSAU_AM_NEAR     = 2'h1,
      DSAU_AM_INDIRECT = 2'h3
   } dsau_amode_t;

   typedef enum logic [1:0]
   {
      DSAU_EXT_WORD   = 2'h0,
      DSAU_EXT_BYTE   = 2'h1,
      DSAU_EXT_SIGN   = 2'h3,
      DSAU_EXT_CLEAR  = 2'h2
   } dsau_ext_t;

   typedef struct packed
   {
      logic        valid;
      logic        is_byte;
      dsau_amode_t mode;
      logic        post_inc;
      logic [15:0] field;
      logic [15:0] pointer;
   } dsau_req_t;
endpackage : dsau_pkg

/* logic/dsau_ext_unit.sv */
// working register merge: word load, byte load, sign widen, upper clear
module dsau_ext_unit
(
   // operands
   input  wire dsau_pkg::dsau_ext_t op_in,
   input  wire logic [15:0]        data_in,
   input  wire logic [15:0]        wreg_old_in,
   // result
   output logic [15:0]             wreg_out
);
   always_comb
   begin
      case (op_in)
         dsau_pkg::DSAU_EXT_BYTE  : wreg_out = {wreg_old_in[15:8], data_in[7:0]};
         dsau_pkg::DSAU_EXT_SIGN  : wreg_out = {{8{data_in[7]}}, data_in[7:0]};
         dsau_pkg::DSAU_EXT_CLEAR : wreg_out = {8'h00, data_in[7:0]};
         default                  : wreg_out = data_in;
      endcase
   end
endmodule : dsau_ext_unit

/* testbench/dsau_far_model.sv */
// far side model: a small register bank and the program space window
module dsau_far_model
(
   // clock
   input  wire logic        clk_sys_in,
   // register read
   input  wire logic        sfr_rd_en_in,
   input  wire logic [15:0] sfr_rd_addr_in,
   output logic [15:0]      sfr_rd_data_out,
   output logic             sfr_rd_hit_out,
   // register write
   input  wire logic [1:0]  sfr_wr_lane_in,
   input  wire logic [15:0] sfr_wr_addr_in,
   input  wire logic [15:0] sfr_wr_data_in,
   // visibility window
   input  wire logic        psv_rd_en_in,
   input  wire logic [14:0] psv_addr_in,
   output logic [15:0]      psv_rd_data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] bank [0:3];
   logic [15:0] junk;
   logic        rd_hit;
   logic        wr_hit;
   initial
   begin
      junk = 16'ha5c3;
      bank = '{default: 16'h0000};
   end
   // idle lines toggle so a stale value never passes for a real one
   always @(posedge clk_sys_in)
      junk <= ~junk;
   assign rd_hit = sfr_rd_en_in && (sfr_rd_addr_in[15:3] == 13'h0058);
   assign wr_hit = (sfr_wr_addr_in[15:3] == 13'h0058);
   // gaps report no hit and show junk, never zero
   assign sfr_rd_hit_out = rd_hit;
   assign sfr_rd_data_out = rd_hit ? bank[sfr_rd_addr_in[2:1]] : junk;
   assign psv_rd_data_out = psv_rd_en_in ? ({1'h1, psv_addr_in} ^ 16'h0f0f) : junk;
   always @(posedge clk_sys_in)
   begin
      if (wr_hit && sfr_wr_lane_in[0])
         bank[sfr_wr_addr_in[2:1]][7:0] <= sfr_wr_data_in[7:0];
      if (wr_hit && sfr_wr_lane_in[1])
         bank[sfr_wr_addr_in[2:1]][15:8] <= sfr_wr_data_in[15:8];
   end
endmodule : dsau_far_model

/* testbench/tb_data_space_access_unit.sv */
// self-checking bench of the data space access unit
module tb_data_space_access_unit;
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      logic [3:0]  fl;
      logic [1:0]  m, x;
      logic [15:0] f, d, ed, ew;
   } dsau_row_t;
   logic                clk_sys_in;
   logic                rst_in;
   dsau_pkg::dsau_req_t rd_req_in, wr_req_in;
   dsau_pkg::dsau_ext_t rd_ext_op_in;
   logic [15:0]         rd_wreg_old_in, wr_data_in, rd_data_out, rd_wreg_out;
   logic [15:0]         rd_ptr_next_out, wr_ptr_next_out, sfr_rd_addr_out, sfr_rd_data_in;
   logic [15:0]         sfr_wr_addr_out, sfr_wr_data_out, psv_rd_data_in;
   logic                rd_valid_out, addr_err_trap_out, addr_err_write_out;
   logic                sfr_rd_en_out, sfr_rd_hit_in, psv_rd_en_out;
   logic [1:0]          sfr_wr_lane_out;
   logic [14:0]         psv_addr_out;
   int                  bad_count;
   int                  cmp_count;
   dsau_row_t           rows [18];
   ////////////////////////////////////////////////////////////////////////////////
   dsau_top dut
   (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .rd_req_in(rd_req_in),
      .rd_ext_op_in(rd_ext_op_in), .rd_wreg_old_in(rd_wreg_old_in), .wr_req_in(wr_req_in),
      .wr_data_in(wr_data_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
      .rd_wreg_out(rd_wreg_out), .rd_ptr_next_out(rd_ptr_next_out),
      .wr_ptr_next_out(wr_ptr_next_out), .addr_err_trap_out(addr_err_trap_out),
      .addr_err_write_out(addr_err_write_out), .sfr_rd_en_out(sfr_rd_en_out),
      .sfr_rd_addr_out(sfr_rd_addr_out), .sfr_rd_data_in(sfr_rd_data_in),
      .sfr_rd_hit_in(sfr_rd_hit_in), .sfr_wr_lane_out(sfr_wr_lane_out),
      .sfr_wr_addr_out(sfr_wr_addr_out), .sfr_wr_data_out(sfr_wr_data_out),
      .psv_rd_en_out(psv_rd_en_out), .psv_addr_out(psv_addr_out),
      .psv_rd_data_in(psv_rd_data_in)
   );
   dsau_far_model far
   (
      .clk_sys_in(clk_sys_in), .sfr_rd_en_in(sfr_rd_en_out), .sfr_rd_addr_in(sfr_rd_addr_out),
      .sfr_rd_data_out(sfr_rd_data_in), .sfr_rd_hit_out(sfr_rd_hit_in),
      .sfr_wr_lane_in(sfr_wr_lane_out), .sfr_wr_addr_in(sfr_wr_addr_out),
      .sfr_wr_data_in(sfr_wr_data_out), .psv_rd_en_in(psv_rd_en_out),
      .psv_addr_in(psv_addr_out), .psv_rd_data_out(psv_rd_data_in)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
         bad_count++;
      if (got !== exp)
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
   endtask : chk16
   task automatic chk1(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
         bad_count++;
      if (got !== exp)
         $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
   endtask : chk1
   // flags: write, byte, post-increment, trap; back to back, so no idle between rows
   task automatic op(input dsau_row_t r);
      dsau_pkg::dsau_req_t q;
      logic [15:0]         ea;
      logic [15:0]         step;
      logic [1:0]          lane;
      ea = (r.m == 2'h1) ? {3'h0, r.f[12:0]} : r.f;
      step = r.fl[2] ? 16'h0001 : 16'h0002;
      lane = r.fl[2] ? (ea[0] ? 2'h2 : 2'h1) : 2'h3;
      if (ea > 16'h07ff || r.fl[0])
         lane = 2'h0;
      q = '{1'h1, r.fl[2], dsau_pkg::dsau_amode_t'(r.m), r.fl[1], r.f, r.f};
      rd_ext_op_in = dsau_pkg::dsau_ext_t'(r.x);
      rd_wreg_old_in = r.d;
      wr_data_in = r.d;
      rd_req_in = r.fl[3] ? '0 : q;
      wr_req_in = r.fl[3] ? q : '0;
      #1;
      if (r.fl[3])
         chk16({14'h0, sfr_wr_lane_out}, {14'h0, lane});
      @(negedge clk_sys_in);
      chk1(rd_valid_out, !r.fl[3]);
      chk1(addr_err_trap_out, r.fl[0]);
      chk1(addr_err_write_out, r.fl[0] & r.fl[3]);
      if (r.fl[1])
         chk16(r.fl[3] ? wr_ptr_next_out : rd_ptr_next_out, r.f + step);
      if (!r.fl[3] && !r.fl[0])
         chk16(rd_data_out, r.ed);
      if (!r.fl[3] && !r.fl[0])
         chk16(rd_wreg_out, r.ew);
   endtask : op
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys_in = 1'h0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   // some twenty operations in 34 cycles with reset; over ten times that before giving up
   initial
   begin
      repeat (400) @(posedge clk_sys_in);
      bad_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      end_of_test();
   end
   initial
   begin
      bad_count = 0;
      cmp_count = 0;
      rst_in = 1'h1;
      rd_req_in = '0;
      wr_req_in = '0;
      rd_ext_op_in = dsau_pkg::DSAU_EXT_WORD;
      rd_wreg_old_in = 16'h0000;
      wr_data_in = 16'h0000;
      rows = '{
         '{4'h8, 2'h0, 2'h0, 16'h0800, 16'h1234, 16'h0000, 16'h0000},
         '{4'h0, 2'h0, 2'h0, 16'h0800, 16'h0000, 16'h1234, 16'h1234},
         '{4'h4, 2'h0, 2'h1, 16'h0801, 16'habcd, 16'h0012, 16'hab12},
         '{4'he, 2'h3, 2'h0, 16'h0801, 16'h00ff, 16'h0000, 16'h0000},
         '{4'h2, 2'h3, 2'h2, 16'h0800, 16'h0000, 16'hff34, 16'h0034},
         '{4'h6, 2'h3, 2'h3, 16'h0801, 16'h0000, 16'h00ff, 16'hffff},
         '{4'h8, 2'h1, 2'h0, 16'he802, 16'h5a5a, 16'h0000, 16'h0000},
         '{4'h0, 2'h0, 2'h0, 16'h0802, 16'h0000, 16'h5a5a, 16'h5a5a},
         '{4'hc, 2'h0, 2'h0, 16'h02c1, 16'h00c3, 16'h0000, 16'h0000},
         '{4'hc, 2'h0, 2'h0, 16'h02c0, 16'h003c, 16'h0000, 16'h0000},
         '{4'h0, 2'h0, 2'h0, 16'h02c0, 16'h0000, 16'hc33c, 16'hc33c},
         '{4'h0, 2'h0, 2'h0, 16'h0100, 16'h0000, 16'h0000, 16'h0000},
         '{4'h8, 2'h0, 2'h0, 16'h4802, 16'hffff, 16'h0000, 16'h0000},
         '{4'h0, 2'h0, 2'h0, 16'h4802, 16'h0000, 16'h0000, 16'h0000},
         '{4'h0, 2'h0, 2'h0, 16'h8124, 16'h0000, 16'h8e2b, 16'h8e2b},
         '{4'h1, 2'h0, 2'h0, 16'h0803, 16'h0000, 16'h0000, 16'h0000},
         '{4'h9, 2'h0, 2'h0, 16'h0803, 16'hdead, 16'h0000, 16'h0000},
         '{4'h0, 2'h0, 2'h0, 16'h0802, 16'h0000, 16'h5a5a, 16'h5a5a}};
      repeat (10) @(negedge clk_sys_in);
      rst_in = 1'h0;
      @(negedge clk_sys_in);
      foreach (rows[i])
      begin
         op(rows[i]);
         $display("test %0d done", i);
      end
      // read and write in one cycle: read sees the old word
      rd_req_in = '{1'h1, 1'h0, dsau_pkg::DSAU_AM_DIRECT, 1'h0, 16'h0802, 16'h0000};
      wr_req_in = '{1'h1, 1'h0, dsau_pkg::DSAU_AM_DIRECT, 1'h0, 16'h0802, 16'h0000};
      wr_data_in = 16'h7777;
      rd_ext_op_in = dsau_pkg::DSAU_EXT_WORD;
      @(negedge clk_sys_in);
      chk16(rd_data_out, 16'h5a5a);
      op('{4'h0, 2'h0, 2'h0, 16'h0802, 16'h0000, 16'h7777, 16'h7777});
      $display("test same cycle done");
      // mid-run reset clears registered outputs, ram keeps its words
      rd_req_in = '0;
      wr_req_in = '0;
      rst_in = 1'h1;
      @(negedge clk_sys_in);
      chk16(rd_ptr_next_out, 16'h0000);
      chk1(addr_err_trap_out, 1'h0);
      chk1(rd_valid_out, 1'h0);
      rst_in = 1'h0;
      @(negedge clk_sys_in);
      op('{4'h0, 2'h0, 2'h0, 16'h0800, 16'h0000, 16'hff34, 16'hff34});
      $display("test reset done");
      end_of_test();
   end
endmodule : tb_data_space_access_unit
